// ===== rtl/dgp_defines.svh
// Register offsets, reset values and field layout of the dual GPIO port.
// Assumes a 32-bit APB slave with byte addresses, one word per register.
`ifndef DGP_DEFINES_SVH
`define DGP_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DGP_OFF_H_DIR 12'h000
`define DGP_OFF_H_DATA 12'h004
`define DGP_OFF_H_PINS 12'h008
`define DGP_OFF_J_DIR 12'h00c
`define DGP_OFF_J_DATA 12'h010
`define DGP_OFF_J_PINS 12'h014
`define DGP_OFF_H_PWM_EN 12'h018
`define DGP_OFF_J_PWM_EN 12'h01c
`define DGP_OFF_H_PWM_VAL 12'h020
`define DGP_OFF_J_PWM_VAL 12'h024

// ****************************************
// Widths and reset values
// ****************************************
`define DGP_PORT_W 8
`define DGP_ADDR_W 12
`define DGP_RST_DIR 8'h00
`define DGP_RST_DATA 8'h00
`define DGP_RST_PWM 8'h00
// Value returned for the write-only direction registers
`define DGP_WO_READ 32'h0000_0000

`endif

// ===== rtl/dgp_pkg.sv
// Types shared by the dual GPIO port.
// Assumes dgp_defines.svh is on the include path.
`include "dgp_defines.svh"

package dgp_pkg;
    typedef logic [`DGP_PORT_W-1:0] dgp_byte_t;
    typedef enum logic [3:0] {
        DGP_REG_H_DIR = 4'h0,
        DGP_REG_H_DATA = 4'h1,
        DGP_REG_H_PINS = 4'h2,
        DGP_REG_J_DIR = 4'h3,
        DGP_REG_J_DATA = 4'h4,
        DGP_REG_J_PINS = 4'h5,
        DGP_REG_H_PWM_EN = 4'h6,
        DGP_REG_J_PWM_EN = 4'h7,
        DGP_REG_H_PWM_VAL = 4'h8,
        DGP_REG_J_PWM_VAL = 4'h9,
        DGP_REG_NONE = 4'hf
    } dgp_reg_t;
endpackage

// ===== rtl/dgp_port.sv
// Two 8-bit GPIO ports with PWM takeover, reached over APB.
// Assumes pins are synchronous to clk; pad logic resolves out/oe_n.
//
// Notes on behaviour
// - Two ports, eight bidirectional pins each, input or output.
// - First port pin carries PWM output when group-one enable is 1.
// - Second port pin carries PWM output when group-two enable is 1.
// - First port direction register is write-only; reads give no bits.
// - Second port direction register is write-only; reads give no bits.
// - First port direction bit 1 makes output, 0 makes input.
// - Second port direction bit 1 makes output, 0 makes input.
// - First port output data register is read/write, drives output pins.
// - Second port output data register is read/write, drives outputs.
// - First port pin read returns data bit where direction is 1.
// - First port pin read returns pin level where direction is 0.
// - Second port pin read returns data bit where direction is 1.
// - Second port pin read returns pin level where direction is 0.
// - First port pin register ignores writes entirely.
// - Second port pin register ignores writes entirely.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dgp_defines.svh"

module dgp_port
    import dgp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DGP_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // First port pins
    input wire logic [7:0] first_port_pins_in,
    output logic [7:0] first_port_pins_out,
    output logic [7:0] first_port_pins_oe_n,
    // Second port pins
    input wire logic [7:0] second_port_pins_in,
    output logic [7:0] second_port_pins_out,
    output logic [7:0] second_port_pins_oe_n
);

    // ****************************************
    // Address decode
    // ****************************************
    function automatic dgp_reg_t dgp_decode(
        input logic [`DGP_ADDR_W-1:0] addr
    );
        dgp_reg_t r;
        r = DGP_REG_NONE;
        case (addr)
            `DGP_OFF_H_DIR: r = DGP_REG_H_DIR;
            `DGP_OFF_H_DATA: r = DGP_REG_H_DATA;
            `DGP_OFF_H_PINS: r = DGP_REG_H_PINS;
            `DGP_OFF_J_DIR: r = DGP_REG_J_DIR;
            `DGP_OFF_J_DATA: r = DGP_REG_J_DATA;
            `DGP_OFF_J_PINS: r = DGP_REG_J_PINS;
            `DGP_OFF_H_PWM_EN: r = DGP_REG_H_PWM_EN;
            `DGP_OFF_J_PWM_EN: r = DGP_REG_J_PWM_EN;
            `DGP_OFF_H_PWM_VAL: r = DGP_REG_H_PWM_VAL;
            `DGP_OFF_J_PWM_VAL: r = DGP_REG_J_PWM_VAL;
            default: r = DGP_REG_NONE;
        endcase
        return r;
    endfunction

    // Pin-state read value, chosen bit by bit
    function automatic dgp_byte_t dgp_pin_view(
        input dgp_byte_t dir,
        input dgp_byte_t data,
        input dgp_byte_t level
    );
        return (dir & data) | (~dir & level);
    endfunction

    dgp_reg_t sel_reg;
    logic setup;
    logic wr_en;
    logic wr_low;
    dgp_byte_t wbyte;

    assign sel_reg = dgp_decode(paddr);
    // One wait-free access: answer comes in the setup cycle's next edge
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign wr_low = wr_en && pstrb[0];
    assign wbyte = pwdata[7:0];

    // ****************************************
    // Port state
    // ****************************************
    dgp_byte_t h_dir;
    dgp_byte_t h_data;
    dgp_byte_t j_dir;
    dgp_byte_t j_data;
    dgp_byte_t h_pwm_en;
    dgp_byte_t j_pwm_en;
    dgp_byte_t h_pwm_val;
    dgp_byte_t j_pwm_val;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            h_dir <= `DGP_RST_DIR;
        end else if (wr_low && sel_reg == DGP_REG_H_DIR) begin
            h_dir <= wbyte;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            j_dir <= `DGP_RST_DIR;
        end else if (wr_low && sel_reg == DGP_REG_J_DIR) begin
            j_dir <= wbyte;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            h_data <= `DGP_RST_DATA;
        end else if (wr_low && sel_reg == DGP_REG_H_DATA) begin
            h_data <= wbyte;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            j_data <= `DGP_RST_DATA;
        end else if (wr_low && sel_reg == DGP_REG_J_DATA) begin
            j_data <= wbyte;
        end
    end

    // PWM enables and levels stand in for the timer, kept in software reach
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            h_pwm_en <= `DGP_RST_PWM;
            j_pwm_en <= `DGP_RST_PWM;
            h_pwm_val <= `DGP_RST_PWM;
            j_pwm_val <= `DGP_RST_PWM;
        end else if (wr_low) begin
            case (sel_reg)
                DGP_REG_H_PWM_EN: h_pwm_en <= wbyte;
                DGP_REG_J_PWM_EN: j_pwm_en <= wbyte;
                DGP_REG_H_PWM_VAL: h_pwm_val <= wbyte;
                DGP_REG_J_PWM_VAL: j_pwm_val <= wbyte;
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    dgp_byte_t next_h_out;
    dgp_byte_t next_h_oe_n;
    dgp_byte_t next_j_out;
    dgp_byte_t next_j_oe_n;

    genvar gi;
    generate
        for (gi = 0; gi < `DGP_PORT_W; gi++) begin : g_pin
            assign next_h_out[gi] = h_pwm_en[gi] ? h_pwm_val[gi]
                                                 : h_data[gi];
            assign next_h_oe_n[gi] = !(h_pwm_en[gi] || h_dir[gi]);
            assign next_j_out[gi] = j_pwm_en[gi] ? j_pwm_val[gi]
                                                 : j_data[gi];
            assign next_j_oe_n[gi] = !(j_pwm_en[gi] || j_dir[gi]);
        end
    endgenerate

    // Registered pads: one cycle after the write, outputs change
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            first_port_pins_out <= 8'h00;
            first_port_pins_oe_n <= 8'hff;
            second_port_pins_out <= 8'h00;
            second_port_pins_oe_n <= 8'hff;
        end else begin
            first_port_pins_out <= next_h_out;
            first_port_pins_oe_n <= next_h_oe_n;
            second_port_pins_out <= next_j_out;
            second_port_pins_oe_n <= next_j_oe_n;
        end
    end

    // ****************************************
    // APB answer
    // ****************************************
    logic [31:0] next_prdata;

    always_comb begin
        next_prdata = 32'h0000_0000;
        case (sel_reg)
            DGP_REG_H_DIR: next_prdata = `DGP_WO_READ;
            DGP_REG_J_DIR: next_prdata = `DGP_WO_READ;
            DGP_REG_H_DATA: next_prdata = {24'h000000, h_data};
            DGP_REG_J_DATA: next_prdata = {24'h000000, j_data};
            DGP_REG_H_PINS: next_prdata = {24'h000000,
                dgp_pin_view(h_dir, h_data, first_port_pins_in)};
            DGP_REG_J_PINS: next_prdata = {24'h000000,
                dgp_pin_view(j_dir, j_data, second_port_pins_in)};
            DGP_REG_H_PWM_EN: next_prdata = {24'h000000, h_pwm_en};
            DGP_REG_J_PWM_EN: next_prdata = {24'h000000, j_pwm_en};
            DGP_REG_H_PWM_VAL: next_prdata = {24'h000000, h_pwm_val};
            DGP_REG_J_PWM_VAL: next_prdata = {24'h000000, j_pwm_val};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // Ready and error rise at the edge ending setup, last one access cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && sel_reg == DGP_REG_NONE;
            if (setup && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

endmodule
`default_nettype wire

// ===== sim/dgp_board.sv
// Board model: resolves the level on one port's pins.
// Assumes the bench gives the level of every pin it leaves undriven.
`timescale 1ns/1ps
`default_nettype none
module dgp_board (
    // Pin drive from the port
    input wire logic [7:0] drv,
    input wire logic [7:0] oe_n,
    // Board level and resolved wire
    input wire logic [7:0] ext,
    output logic [7:0] lvl
);
    assign lvl = (drv & ~oe_n) | (ext & oe_n);
endmodule
`default_nettype wire

// ===== sim/dgp_port_assertions.sv
// Protocol and pin checks for the dual GPIO port.
// Assumes it is bound to dgp_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "dgp_defines.svh"
module dgp_port_assertions (
    // Clock, reset and APB
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Pins
    input wire logic [7:0] first_port_pins_in,
    input wire logic [7:0] first_port_pins_out,
    input wire logic [7:0] first_port_pins_oe_n,
    input wire logic [7:0] second_port_pins_in,
    input wire logic [7:0] second_port_pins_out,
    input wire logic [7:0] second_port_pins_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_setup(logic w, logic [11:0] a);
        psel && !penable && pwrite == w && paddr == a;
    endsequence
    // Pins not driven must read back their own level
    property p_h_lvl;
        s_setup(1'b0, `DGP_OFF_H_PINS) |=> ((prdata[7:0]
            ^ $past(first_port_pins_in)) & first_port_pins_oe_n) == 8'h00;
    endproperty
    property p_j_lvl;
        s_setup(1'b0, `DGP_OFF_J_PINS) |=> ((prdata[7:0]
            ^ $past(second_port_pins_in)) & second_port_pins_oe_n) == 8'h00;
    endproperty
    // Drive value and enable both checked: a stray write shows in either
    property p_h_wr;
        s_setup(1'b1, `DGP_OFF_H_PINS) ##1 pready
            |=> ($stable(first_port_pins_oe_n)
            && $stable(first_port_pins_out)) [*2];
    endproperty
    property p_j_wr;
        s_setup(1'b1, `DGP_OFF_J_PINS) ##1 pready
            |=> ($stable(second_port_pins_oe_n)
            && $stable(second_port_pins_out)) [*2];
    endproperty
    property p_answer; psel && !penable |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_h_dir;
        s_setup(1'b0, `DGP_OFF_H_DIR) |=> prdata == `DGP_WO_READ;
    endproperty
    property p_j_dir;
        s_setup(1'b0, `DGP_OFF_J_DIR) |=> prdata == `DGP_WO_READ;
    endproperty
    a_h_lvl: assert property (p_h_lvl)
        else $error("first port level misread");
    a_j_lvl: assert property (p_j_lvl)
        else $error("second port level misread");
    a_h_wr: assert property (p_h_wr)
        else $error("first port pin write had effect");
    a_j_wr: assert property (p_j_wr)
        else $error("second port pin write had effect");
    a_answer: assert property (p_answer) else $error("no answer");
    a_pulse: assert property (p_pulse) else $error("ready too long");
    a_h_dir: assert property (p_h_dir)
        else $error("first direction readable");
    a_j_dir: assert property (p_j_dir)
        else $error("second direction readable");
endmodule
bind dgp_port dgp_port_assertions u_chk (.clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .first_port_pins_in,
    .first_port_pins_out, .first_port_pins_oe_n, .second_port_pins_in,
    .second_port_pins_out, .second_port_pins_oe_n);
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the dual GPIO port over APB.
// Assumes dgp_port, dgp_board and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "dgp_defines.svh"
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); \
    end \
end
module testbench;
    import dgp_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    dgp_byte_t ext [2] = '{8'h00, 8'h00};
    dgp_byte_t pin_in [2], pin_out [2], oe_n [2];
    int n_mismatch = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    dgp_port dut (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .first_port_pins_in(pin_in[0]), .first_port_pins_out(pin_out[0]),
        .first_port_pins_oe_n(oe_n[0]), .second_port_pins_in(pin_in[1]),
        .second_port_pins_out(pin_out[1]), .second_port_pins_oe_n(oe_n[1]));
    dgp_board board_h (.drv(pin_out[0]), .oe_n(oe_n[0]), .ext(ext[0]),
        .lvl(pin_in[0]));
    dgp_board board_j (.drv(pin_out[1]), .oe_n(oe_n[1]), .ext(ext[1]),
        .lvl(pin_in[1]));
    // Expected level on each pin
    function automatic dgp_byte_t f_lvl(dgp_byte_t d, v, e, w, x);
        dgp_byte_t en;
        en = e | d;
        return (en & ((e & w) | (~e & v))) | (~en & x);
    endfunction
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] dat);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        dgp_byte_t d, v, e, w, x, l;
        logic [11:0] a;
        void'($urandom(50));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            bus(1'b0, 12'(12 * p + 4), 32'h0);
            `CHK(rd, 32'h0)
            `CHK(oe_n[p], 8'hff)
        end
        bus(1'b0, 12'h030, 32'h0);
        `CHK(err, 1'b1)
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) begin
                a = 12'(12 * p);
                d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
                v = 8'($urandom);
                e = (i < 4) ? 8'h00 : 8'($urandom);
                w = 8'($urandom);
                x = 8'($urandom);
                l = f_lvl(d, v, e, w, x);
                ext[p] <= x;
                bus(1'b1, a, {24'h0, d});
                // output values go to the data register
                bus(1'b1, a + 12'h004, {24'h0, v});
                bus(1'b1, `DGP_OFF_H_PWM_EN + 12'(4 * p), {24'h0, e});
                bus(1'b1, `DGP_OFF_H_PWM_VAL + 12'(4 * p), {24'h0, w});
                bus(1'b1, a + 12'h008, {24'h0, ~v});
                // Low byte strobe off: the data write must be dropped
                pstrb <= 4'he;
                bus(1'b1, a + 12'h004, {24'h0, ~v});
                pstrb <= 4'hf;
                bus(1'b0, a, 32'h0);
                `CHK(rd, `DGP_WO_READ)
                bus(1'b0, a + 12'h004, 32'h0);
                `CHK(rd, {24'h0, v})
                bus(1'b0, a + 12'h008, 32'h0);
                `CHK(rd[7:0], (d & v) | (~d & l))
                `CHK(oe_n[p], ~(e | d))
                `CHK(pin_in[p], l)
            end
            $display("test port %0d done", p);
        end
        // Mid-run reset must bring every pin back to input
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            bus(1'b0, 12'(12 * p + 4), 32'h0);
            `CHK(rd, 32'h0)
            `CHK(oe_n[p], 8'hff)
        end
        $display("test mid reset done");
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
